/* File: core/rpl_pkg.sv */
// Constants, register map and routing tables of the pin routing matrix
package rpl_pkg;

	// ---------------------------------------------------------------
	// Bus geometry
	// ---------------------------------------------------------------
	localparam int IDX_W  = 13;
	localparam int ADDR_W = IDX_W + 2;
	localparam int DATA_W = 32;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_LOCK = 13'h1e8f;

	localparam int NUM_IN  = 13;
	localparam int NUM_OUT = 17;

	localparam logic [IDX_W-1:0] IN_SEL_IDX [NUM_IN] = '{
		13'h1e90, 13'h1e91, 13'h1e92, 13'h1e93, 13'h1e9c, 13'h1ea1, 13'h1ea2,
		13'h1ec3, 13'h1ec5, 13'h1ec6, 13'h1ec7, 13'h1ecb, 13'h1ecc
	};

	localparam logic [IDX_W-1:0] OUT_SEL_IDX [NUM_OUT] = '{
		13'h1f10, 13'h1f11, 13'h1f12, 13'h1f14, 13'h1f15, 13'h1f1c, 13'h1f1d,
		13'h1f1e, 13'h1f1f, 13'h1f20, 13'h1f21, 13'h1f22, 13'h1f23, 13'h1f24,
		13'h1f25, 13'h1f26, 13'h1f27
	};

	// ---------------------------------------------------------------
	// Pins: three ports of eight, port A in the low byte
	// ---------------------------------------------------------------
	localparam int NUM_PORTS = 3;
	localparam int PORT_W    = 8;
	localparam int NUM_PINS  = NUM_PORTS * PORT_W;

	localparam logic [4:0] OUT_PIN_POS [NUM_OUT] = '{
		5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
		5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17
	};

	// ---------------------------------------------------------------
	// Selector fields
	// ---------------------------------------------------------------
	localparam int SEL_W      = 6;
	localparam int PORT_LSB   = 3;
	localparam int PORT_MSB   = 5;
	localparam int PIN_LSB    = 0;
	localparam int PIN_MSB    = 2;
	localparam logic [2:0] PORT_A = 3'h0;
	localparam logic [2:0] PORT_B = 3'h1;
	localparam logic [2:0] PORT_C = 3'h2;
	localparam int LOCK_BIT   = 0;

	// Reset defaults (selectors at power reset, lock bit at any reset), entry i sits at bits i*6
	localparam logic [NUM_IN*SEL_W-1:0] IN_DEFAULT_VEC = {
		6'h0f, 6'h0d, 6'h16, 6'h0e, 6'h0c, 6'h12, 6'h13,
		6'h15, 6'h05, 6'h04, 6'h05, 6'h02, 6'h02
	};
	localparam logic [SEL_W-1:0] OUT_DEFAULT = 6'h00;
	localparam logic             LOCK_RESET  = 1'b0;

	// ---------------------------------------------------------------
	// Output source codes
	// ---------------------------------------------------------------
	localparam logic [SEL_W-1:0] SRC_LATCH = 6'h00;
	localparam logic [SEL_W-1:0] SRC_FIRST = 6'h01;
	localparam logic [SEL_W-1:0] SRC_TMR0  = 6'h09;
	localparam int               NUM_SRC   = 9;

	// ---------------------------------------------------------------
	// Key sequence
	// ---------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_HALF,
		KEY_ARMED
	} rpl_key_type;

endpackage : rpl_pkg

/* File: core/rpl_sel_reg.sv */
// One routing selector register with power-reset default
`timescale 1ns/1ps

module rpl_sel_reg
	import rpl_pkg::*;
#(
	parameter logic [SEL_W-1:0] DEFAULT = '0
) (
	input  wire logic             clk_i,
	input  wire logic             cke_i,
	input  wire logic             pwr_rst_i,
	input  wire logic             wr_i,
	input  wire logic [SEL_W-1:0] data_i,
	output logic      [SEL_W-1:0] sel_o
);

	logic [SEL_W-1:0] sel_q;

	always_ff @(posedge clk_i) begin
		if (pwr_rst_i) begin
			sel_q <= DEFAULT;
		end else if (cke_i && wr_i) begin
			sel_q <= data_i;
		end
	end

	assign sel_o = sel_q;

endmodule : rpl_sel_reg

/* File: core/rpl_top.sv */
// Pin routing matrix: APB selector registers, key-protected lock, routing
`timescale 1ns/1ps

module rpl_top
	import rpl_pkg::*;
(
	input  wire logic                MCLK_I,
	input  wire logic                SYS_RST_I,
	input  wire logic                PWR_RST_I,
	input  wire logic                CKE_I,
	input  wire logic                ONE_WAY_CFG_I,
	input  wire logic                PSEL_I,
	input  wire logic                PENABLE_I,
	input  wire logic                PWRITE_I,
	input  wire logic [ADDR_W-1:0]   PADDR_I,
	input  wire logic [DATA_W-1:0]   PWDATA_I,
	output logic      [DATA_W-1:0]   PRDATA_O,
	output logic                     PREADY_O,
	output logic                     PSLVERR_O,
	input  wire logic [NUM_PINS-1:0] PIN_IN_I,
	input  wire logic [NUM_PINS-1:0] LAT_I,
	input  wire logic [NUM_SRC-1:0]  PERIPH_SRC_I,
	output logic      [NUM_IN-1:0]   PERIPH_IN_O,
	output logic      [NUM_PINS-1:0] PIN_OUT_O,
	output logic      [NUM_PINS-1:0] PORT_READ_O,
	output logic                     LOCKED_O
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic                       any_rst;
	logic [IDX_W-1:0]           reg_idx;
	logic                       aligned;
	logic                       lock_hit;
	logic [NUM_IN-1:0]          in_hit;
	logic [NUM_OUT-1:0]         out_hit;
	logic                       mapped;
	logic                       wr_commit;
	logic                       sel_wr_ok;
	logic [7:0]                 wbyte;
	logic [DATA_W-1:0]          rd_data;

	logic                       pready_q;
	logic                       pslverr_q;
	logic [DATA_W-1:0]          prdata_q;

	rpl_key_type                key_q;
	logic                       locked_q;

	logic [SEL_W-1:0]           in_sel  [NUM_IN];
	logic [SEL_W-1:0]           out_sel [NUM_OUT];
	logic [NUM_IN*SEL_W-1:0]    in_sel_vec;
	logic [NUM_OUT*SEL_W-1:0]   out_sel_vec;

	logic [NUM_IN-1:0]          periph_in_d;
	logic [NUM_IN-1:0]          periph_in_q;
	logic [NUM_PINS-1:0]        pin_out_d;
	logic [NUM_PINS-1:0]        pin_out_q;
	logic [NUM_PINS-1:0]        port_rd_q;

	assign any_rst = SYS_RST_I || PWR_RST_I;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	assign reg_idx  = PADDR_I[ADDR_W-1:2];
	assign aligned  = (PADDR_I[1:0] == 2'b00);
	assign lock_hit = aligned && (reg_idx == IDX_LOCK);
	assign wbyte    = PWDATA_I[7:0];

	always_comb begin
		in_hit  = '0;
		out_hit = '0;
		for (int i = 0; i < NUM_IN; i++) begin
			in_hit[i] = aligned && (reg_idx == IN_SEL_IDX[i]);
		end
		for (int j = 0; j < NUM_OUT; j++) begin
			out_hit[j] = aligned && (reg_idx == OUT_SEL_IDX[j]);
		end
	end

	assign mapped = lock_hit || (|in_hit) || (|out_hit);

	// A write lands only at the edge where the master sees pready high
	assign wr_commit = CKE_I && PSEL_I && PENABLE_I && PWRITE_I && pready_q;

	assign sel_wr_ok = wr_commit && !locked_q;

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	always_comb begin
		rd_data = '0;
		// lock bit alone in bit 0
		if (lock_hit) begin
			rd_data[LOCK_BIT] = locked_q;
		end
		for (int i = 0; i < NUM_IN; i++) begin
			if (in_hit[i]) begin
				rd_data[SEL_W-1:0] = in_sel[i];
			end
		end
		for (int j = 0; j < NUM_OUT; j++) begin
			if (out_hit[j]) begin
				rd_data[SEL_W-1:0] = out_sel[j];
			end
		end
	end

	// ---------------------------------------------------------------
	// APB slave: one wait state, answer registered
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (any_rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else if (CKE_I) begin
			if (PSEL_I && PENABLE_I && !pready_q) begin
				pready_q  <= 1'b1;
				pslverr_q <= !mapped;
				prdata_q  <= (!PWRITE_I && mapped) ? rd_data : '0;
			end else begin
				pready_q  <= 1'b0;
				pslverr_q <= 1'b0;
				prdata_q  <= '0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Key sequence and lock bit
	// ---------------------------------------------------------------
	// Any write that breaks the key pair, except a repeated first key, drops the sequence, so an
	// interrupt handler writing elsewhere between keys disarms it.
	always_ff @(posedge MCLK_I) begin
		if (any_rst) begin
			key_q <= KEY_IDLE;
		end else if (wr_commit) begin
			if (!lock_hit) begin
				key_q <= KEY_IDLE;
			end else begin
				unique case (key_q)
					KEY_IDLE: begin
						key_q <= (wbyte == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
					end
					KEY_HALF: begin
						if (wbyte == KEY_SECOND) begin
							key_q <= KEY_ARMED;
						end else if (wbyte == KEY_FIRST) begin
							key_q <= KEY_HALF;
						end else begin
							key_q <= KEY_IDLE;
						end
					end
					KEY_ARMED: begin
						key_q <= KEY_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (any_rst) begin
			locked_q <= LOCK_RESET;
		end else if (wr_commit && lock_hit && key_q == KEY_ARMED) begin
			if (wbyte[LOCK_BIT] || !ONE_WAY_CFG_I) begin
				locked_q <= wbyte[LOCK_BIT];
			end
		end
	end

	// ---------------------------------------------------------------
	// Selector registers
	// ---------------------------------------------------------------
	generate
		for (genvar i = 0; i < NUM_IN; i++) begin : g_in
			rpl_sel_reg #(
				.DEFAULT (IN_DEFAULT_VEC[i*SEL_W +: SEL_W])
			) u_in_sel (
				.clk_i     (MCLK_I),
				.cke_i     (CKE_I),
				.pwr_rst_i (PWR_RST_I),
				.wr_i      (sel_wr_ok && in_hit[i]),
				.data_i    (PWDATA_I[SEL_W-1:0]),
				.sel_o     (in_sel[i])
			);
			assign in_sel_vec[i*SEL_W +: SEL_W] = in_sel[i];
		end
		// six-bit source code, zero at power reset
		for (genvar j = 0; j < NUM_OUT; j++) begin : g_out
			rpl_sel_reg #(
				.DEFAULT (OUT_DEFAULT)
			) u_out_sel (
				.clk_i     (MCLK_I),
				.cke_i     (CKE_I),
				.pwr_rst_i (PWR_RST_I),
				.wr_i      (sel_wr_ok && out_hit[j]),
				.data_i    (PWDATA_I[SEL_W-1:0]),
				.sel_o     (out_sel[j])
			);
			assign out_sel_vec[j*SEL_W +: SEL_W] = out_sel[j];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Routing
	// ---------------------------------------------------------------
	// routing depends on no power state, so it holds in sleep
	always_comb begin
		periph_in_d = '0;
		for (int i = 0; i < NUM_IN; i++) begin
			if (in_sel[i][PORT_MSB:PORT_LSB] <= PORT_C) begin
				periph_in_d[i] = PIN_IN_I[{in_sel[i][PORT_LSB+1:PORT_LSB],
					in_sel[i][PIN_MSB:PIN_LSB]}];
			end
		end
	end

	// Pins without a selector always follow their latch
	always_comb begin
		pin_out_d = LAT_I;
		for (int j = 0; j < NUM_OUT; j++) begin
			// others fall back to the latch
			if (out_sel[j] >= SRC_FIRST && out_sel[j] <= SRC_TMR0) begin
				pin_out_d[OUT_PIN_POS[j]] = PERIPH_SRC_I[4'(out_sel[j] - SRC_FIRST)];
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (any_rst) begin
			periph_in_q <= '0;
			pin_out_q   <= '0;
		end else if (CKE_I) begin
			periph_in_q <= periph_in_d;
			pin_out_q   <= pin_out_d;
		end
	end

	// raw pin level, independent of input routing
	always_ff @(posedge MCLK_I) begin
		if (any_rst) begin
			port_rd_q <= '0;
		end else if (CKE_I) begin
			port_rd_q <= PIN_IN_I;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign PRDATA_O    = prdata_q;
	assign PREADY_O    = pready_q;
	assign PSLVERR_O   = pslverr_q;
	assign PERIPH_IN_O = periph_in_q;
	assign PIN_OUT_O   = pin_out_q;
	assign PORT_READ_O = port_rd_q;
	assign LOCKED_O    = locked_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge MCLK_I);
	endclocking

	default disable iff (any_rst || !CKE_I);

	sequence s_armed_lock_write;
		wr_commit && lock_hit && (key_q == KEY_ARMED);
	endsequence

	sequence s_half_then_second;
		(key_q == KEY_HALF) && wr_commit && lock_hit && (wbyte == KEY_SECOND);
	endsequence

	// lock bit moves only after an armed write
	a_key_required: assert property (
		!$stable(locked_q) |-> $past(key_q == KEY_ARMED) && $past(wr_commit && lock_hit)
	) else $error("lock bit changed without key pair");

	a_key_arms: assert property (
		s_half_then_second |=> (key_q == KEY_ARMED)
	) else $error("key pair did not arm lock");

	a_one_way_hold: assert property (
		ONE_WAY_CFG_I && locked_q |=> locked_q
	) else $error("one-way lock was cleared");

	a_two_way_clear: assert property (
		s_armed_lock_write ##0 (!wbyte[LOCK_BIT] && !ONE_WAY_CFG_I) |=> !locked_q
	) else $error("two-way unlock failed");

	a_pwr_defaults: assert property (disable iff (1'b0)
		PWR_RST_I |=> (in_sel_vec == IN_DEFAULT_VEC) && (out_sel_vec == '0)
	) else $error("power reset did not restore selectors");

	a_sys_keeps: assert property (disable iff (1'b0)
		SYS_RST_I && !PWR_RST_I |=> $stable(in_sel_vec) && $stable(out_sel_vec)
	) else $error("general reset changed selectors");

	a_lock_reset: assert property (disable iff (1'b0)
		any_rst |=> !locked_q && !LOCKED_O
	) else $error("lock bit survived reset");

	a_locked_hold: assert property (
		locked_q |=> $stable(in_sel_vec) && $stable(out_sel_vec)
	) else $error("selector changed while locked");

	// upper lock register bits read zero
	a_lock_read: assert property (
		PSEL_I && PENABLE_I && !PWRITE_I && lock_hit && !pready_q
		|=> PREADY_O && (PRDATA_O[DATA_W-1:1] == '0) && (PRDATA_O[0] == $past(locked_q))
	) else $error("lock register read wrong");

	a_in_route: assert property (
		in_sel[0][PORT_MSB:PORT_LSB] == PORT_B
		|=> PERIPH_IN_O[0] == $past(PIN_IN_I[PORT_W + int'(in_sel[0][PIN_MSB:PIN_LSB])])
	) else $error("input routing wrong");

	// timer output code drives the pin
	a_src_decode: assert property (
		out_sel[0] == SRC_TMR0 |=> PIN_OUT_O[0] == $past(PERIPH_SRC_I[NUM_SRC-1])
	) else $error("source decode wrong");

	a_src_undef: assert property (
		out_sel[0] > SRC_TMR0 |=> PIN_OUT_O[0] == $past(LAT_I[0])
	) else $error("undefined code not on latch");

	a_port_read: assert property (
		1'b1 |=> PORT_READ_O == $past(PIN_IN_I)
	) else $error("port read not pin level");

endmodule : rpl_top

/* File: tb/rpl_far_model.sv */
// Peripherals and pins beside the routing matrix
`timescale 1ns/1ps

module rpl_far_model
	import rpl_pkg::*;
(
	input  wire logic                clk_i,
	output logic      [NUM_PINS-1:0] pin_o,
	output logic      [NUM_PINS-1:0] lat_o,
	output logic      [NUM_SRC-1:0]  src_o
);
	// Unknown until the first edge, which falls inside the bench reset
	// pins move freely
	// New values every cycle, so a stale routing path cannot match by luck
	always @(posedge clk_i) begin
		pin_o <= NUM_PINS'($urandom);
		lat_o <= NUM_PINS'($urandom);
		src_o <= NUM_SRC'($urandom);
	end
endmodule : rpl_far_model

/* File: tb/rpl_bench.sv */
// Self-checking bench for the pin routing matrix
`timescale 1ns/1ps

module rpl_bench
	import rpl_pkg::*;
;
	logic                clk = 1'b0;
	logic                sys_rst = 1'b1;
	logic                pwr_rst = 1'b1;
	logic                cke = 1'b1;
	logic                one_way = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [ADDR_W-1:0]   paddr = '0;
	logic [DATA_W-1:0]   pwdata = '0;
	logic [DATA_W-1:0]   prdata;
	logic                pready;
	logic                pslverr;
	logic [NUM_PINS-1:0] pin_in, lat, pin_q, lat_q, pin_out, port_read;
	logic [NUM_SRC-1:0]  src, src_q;
	logic [NUM_IN-1:0]   periph_in;
	logic                locked;
	logic [SEL_W-1:0]    in_m [NUM_IN];
	logic [SEL_W-1:0]    out_m [NUM_OUT];
	logic                lock_m;
	logic [31:0]         rd;
	logic                err;
	int                  n_fail = 0;
	int                  checks_done = 0;

	always #25 clk = ~clk;

	always @(posedge clk) begin
		pin_q <= pin_in;
		lat_q <= lat;
		src_q <= src;
	end

	rpl_far_model rpl_far_model_i (.clk_i(clk), .pin_o(pin_in), .lat_o(lat), .src_o(src));

	rpl_top rpl_top_i (
		.MCLK_I(clk), .SYS_RST_I(sys_rst), .PWR_RST_I(pwr_rst), .CKE_I(cke),
		.ONE_WAY_CFG_I(one_way), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .PIN_IN_I(pin_in), .LAT_I(lat), .PERIPH_SRC_I(src),
		.PERIPH_IN_O(periph_in), .PIN_OUT_O(pin_out), .PORT_READ_O(port_read),
		.LOCKED_O(locked)
	);

	// ---------------------------------------------------------------
	// Checking and bus tasks
	// ---------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			print_verdict();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	task automatic rdchk(input string nm, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(nm, rd, exp);
		chk("rd_err", 32'(err), 32'h0000_0000);
	endtask : rdchk

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
		chk("wr_err", 32'(err), 32'h0000_0000);
	endtask : wr

	task automatic put(input bit is_out, input int k, input logic [31:0] d);
		wr(is_out ? OUT_SEL_IDX[k] : IN_SEL_IDX[k], d);
		if (!lock_m && is_out)
			out_m[k] = d[5:0];
		else if (!lock_m)
			in_m[k] = d[5:0];
	endtask : put

	task automatic keys();
		wr(IDX_LOCK, 32'h0000_0055);
		wr(IDX_LOCK, 32'h0000_00aa);
	endtask : keys

	task automatic lk(input logic exp);
		repeat (2) @(negedge clk);
		chk("locked", 32'(locked), 32'(exp));
		// Return on a rising edge, so the next drive lands there
		@(posedge clk);
	endtask : lk

	task automatic check_all();
		for (int k = 0; k < NUM_IN; k++)
			rdchk("in_sel", IN_SEL_IDX[k], 32'(in_m[k]));
		for (int k = 0; k < NUM_OUT; k++)
			rdchk("out_sel", OUT_SEL_IDX[k], 32'(out_m[k]));
	endtask : check_all

	// ---------------------------------------------------------------
	// Expected routing
	// ---------------------------------------------------------------
	function automatic logic [NUM_PINS-1:0] exp_pins();
		logic [NUM_PINS-1:0] e;
		e = lat_q;
		for (int k = 0; k < NUM_OUT; k++)
			if (out_m[k] >= 6'h01 && out_m[k] <= 6'h09)
				e[OUT_PIN_POS[k]] = src_q[out_m[k] - 6'h01];
		return e;
	endfunction : exp_pins

	function automatic logic [NUM_IN-1:0] exp_in();
		logic [NUM_IN-1:0] e;
		e = '0;
		for (int i = 0; i < NUM_IN; i++)
			if (in_m[i][5:3] < 3'h3)
				e[i] = pin_q[{in_m[i][5:3], in_m[i][2:0]}];
		return e;
	endfunction : exp_in

	task automatic check_route(input int n);
		// The edge that lands a write still routes with the old selector
		@(posedge clk);
		repeat (n) begin
			@(negedge clk);
			chk("pin_out", 32'(pin_out), 32'(exp_pins()));
			chk("periph_in", 32'(periph_in), 32'(exp_in()));
			chk("port_read", 32'(port_read), 32'(pin_q));
		end
		@(posedge clk);
	endtask : check_route

	task automatic defaults();
		for (int k = 0; k < NUM_IN; k++)
			in_m[k] = IN_DEFAULT_VEC[k*SEL_W +: SEL_W];
		for (int k = 0; k < NUM_OUT; k++)
			out_m[k] = OUT_DEFAULT;
		lock_m = 1'b0;
	endtask : defaults

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'h711fb37a));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		pwr_rst <= 1'b0;
		defaults();
		check_all();
		rdchk("lock", IDX_LOCK, 32'h0000_0000);
		apb(1'b0, 13'h1f13, 32'h0000_0000);
		chk("unmapped_err", 32'(err), 32'h0000_0001);
		chk("unmapped_rd", rd, 32'h0000_0000);
		apb(1'b1, 13'h1e94, 32'h0000_0011);
		chk("unmapped_err", 32'(err), 32'h0000_0001);
		// Round 0 sets every defined source code once, the rest is random
		for (int r = 0; r < 3; r++) begin
			for (int k = 0; k < NUM_OUT; k++)
				put(1, k, (r == 0 && k < 10) ? 32'(k) : $urandom % 32'd64);
			for (int k = 0; k < NUM_IN; k++)
				put(0, k, $urandom);
			check_all();
			check_route(8);
		end
		// Corner cases: first input on port B, first pin on the timer code
		put(0, 0, 32'({PORT_B, 3'h6}));
		put(1, 0, 32'h0000_0009);
		put(0, 9, 32'({PORT_C, 3'h5}));
		put(1, 14, 32'h0000_0008);
		check_route(6);
		put(1, 0, 32'h0000_003f);
		check_route(2);
		wr(IDX_LOCK, 32'h0000_0001);
		lk(1'b0);
		wr(IDX_LOCK, 32'h0000_0055);
		put(1, 0, 32'h0000_0003);
		wr(IDX_LOCK, 32'h0000_00aa);
		wr(IDX_LOCK, 32'h0000_0001);
		lk(1'b0);
		keys();
		wr(IDX_LOCK, 32'hffff_fffe);
		lk(1'b0);
		keys();
		wr(IDX_LOCK, 32'h0000_0003);
		lock_m = 1'b1;
		lk(1'b1);
		rdchk("lock", IDX_LOCK, 32'h0000_0001);
		put(1, 3, 32'h0000_0009);
		put(0, 2, 32'h0000_0017);
		check_all();
		keys();
		wr(IDX_LOCK, 32'h0000_0000);
		lock_m = 1'b0;
		lk(1'b0);
		keys();
		wr(IDX_LOCK, 32'h0000_0001);
		lk(1'b1);
		keys();
		wr(IDX_LOCK, 32'h0000_0000);
		lk(1'b0);
		one_way <= 1'b1;
		keys();
		wr(IDX_LOCK, 32'h0000_0001);
		lock_m = 1'b1;
		lk(1'b1);
		keys();
		wr(IDX_LOCK, 32'h0000_0000);
		lk(1'b1);
		// Frozen clock stands in for sleep
		cke <= 1'b0;
		repeat (20) @(posedge clk);
		cke <= 1'b1;
		check_all();
		check_route(4);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		lock_m = 1'b0;
		lk(1'b0);
		check_all();
		keys();
		wr(IDX_LOCK, 32'h0000_0001);
		lk(1'b1);
		pwr_rst <= 1'b1;
		repeat (2) @(posedge clk);
		pwr_rst <= 1'b0;
		defaults();
		lk(1'b0);
		check_all();
		check_route(4);
		print_verdict();
	end
endmodule : rpl_bench
